// ==== hdl/rfre_defines.vh ====
// Constants for the remap fault reason encoder: codes, register map, fields.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef RFRE_DEFINES_VH
`define RFRE_DEFINES_VH

// ----------------------------------------------------------------------------
// Fault reason codes
// ----------------------------------------------------------------------------
`define RFRE_RSN_NONE        8'h00
`define RFRE_RSN_PTE_RSVD    8'h0c
`define RFRE_RSN_KIND_BLOCK  8'h0d
`define RFRE_RSN_FMT_RSVD    8'h20
`define RFRE_RSN_SLOT_RANGE  8'h21
`define RFRE_RSN_ENTRY_INVAL 8'h22
`define RFRE_RSN_FETCH_ERR   8'h23
`define RFRE_RSN_ENTRY_RSVD  8'h24
`define RFRE_RSN_LEGACY_BLK  8'h25
`define RFRE_RSN_REQ_CHECK   8'h26

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define RFRE_ADDR_CTRL       12'h000
`define RFRE_ADDR_STATUS     12'h004
`define RFRE_ADDR_MASK       12'h008
`define RFRE_ADDR_LAST       12'h00c
`define RFRE_ADDR_COUNT      12'h010

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define RFRE_CTRL_WIDE_BIT   0
`define RFRE_CTRL_LEGACY_BIT 1
`define RFRE_CTRL_SIZE_LSB   4
`define RFRE_CTRL_SIZE_MSB   7
`define RFRE_CTRL_RESET      32'h0000_0002
`define RFRE_ST_XLAT_BIT     0
`define RFRE_ST_IRQ_BIT      1
`define RFRE_MASK_RESET      2'h0

// ----------------------------------------------------------------------------
// Requester check kinds
// ----------------------------------------------------------------------------
`define RFRE_CHK_NONE        2'h0
`define RFRE_CHK_MATCH       2'h1
`define RFRE_CHK_BUS_RANGE   2'h2

`endif

// ==== hdl/rfre_req_check.v ====
// Requester identity check against a remap table entry.
// Assumes all inputs are stable on one clock; purely combinational.
`timescale 1ns/1ps
`include "rfre_defines.vh"

module rfre_req_check (
   // Request side
   input  wire [15:0] source_id,
   // Entry side
   input  wire [15:0] requester_tag,
   input  wire [1:0]  requester_check_kind,
   input  wire [1:0]  requester_match_mask,
   // Verdict
   output reg         check_fail
);

   // ----------------------------------------------------------------------------
   // Identity compare
   // ----------------------------------------------------------------------------
   reg [15:0] ignore_bits;

   // Mask widens the don't-care function field from bit 2 downward
   always @* begin
      ignore_bits = 16'h0000;
      case (requester_match_mask)
         2'h1:    ignore_bits = 16'h0004;
         2'h2:    ignore_bits = 16'h0006;
         2'h3:    ignore_bits = 16'h0007;
         default: ignore_bits = 16'h0000;
      endcase
      case (requester_check_kind)
         `RFRE_CHK_NONE:     check_fail = 1'b0;
         `RFRE_CHK_MATCH:    check_fail = |((source_id ^ requester_tag) & ~ignore_bits);
         // Bus number must lie inside the tag's [start, end] bus window
         `RFRE_CHK_BUS_RANGE: check_fail = (source_id[15:8] < requester_tag[15:8]) ||
                                           (source_id[15:8] > requester_tag[7:0]);
         // Undefined kind can never be trusted, so it fails closed
         default:            check_fail = 1'b1;
      endcase
   end

endmodule // rfre_req_check

// ==== hdl/rfre_top.v ====
// Remap fault reason encoder: classifies translation and interrupt remap
// faults into 8-bit reason codes, with an APB register slave and interrupt.
// Assumes all fault-condition inputs come from logic on CLK, one check per
// strobe, and that the APB master is on the same clock.
// Only the defined codes can leave; reserved values are filtered out.
//
// Contract
// - PTE with R/W set, reserved nonzero: 0Ch
// - Translation-kind blocked request reports 0Dh
// - Remappable request reserved bits set: 20h
// - Slot beyond configured table size: 21h
// - Selected entry not valid: 22h
// - Table fetch access error: 23h
// - Valid entry reserved field nonzero: 24h
// - Legacy format blocked when disallowed: 25h
// - Requester identity check fails: 26h
// - Reason code zero is never reported
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "rfre_defines.vh"

module rfre_top #(
   parameter ALT_PLATFORM = 0,   // 1: legacy-format interrupts always blocked
   parameter SLOT_W       = 16,  // Width of the interrupt slot number
   parameter COUNT_W      = 16   // Width of the fault counter
) (
   // Clock and reset
   input  wire               CLK,
   input  wire               RESET_N,
   // APB slave
   input  wire               PSEL,
   input  wire               PENABLE,
   input  wire               PWRITE,
   input  wire [11:0]        PADDR,
   input  wire [31:0]        PWDATA,
   output wire [31:0]        PRDATA,
   output wire               PREADY,
   output wire               PSLVERR,
   // Translation fault check
   input  wire               XLAT_CHK,
   input  wire               XLAT_PTE_RW_SET,
   input  wire               XLAT_PTE_RSVD_NZ,
   input  wire               XLAT_KIND_BLOCKED,
   // Interrupt remap fault check
   input  wire               IRQ_CHK,
   input  wire               IRQ_REMAPPABLE,
   input  wire               IRQ_FMT_RSVD,
   input  wire [SLOT_W-1:0]  IRQ_SLOT,
   input  wire [15:0]        IRQ_SOURCE_ID,
   input  wire               IRQ_FETCH_ERR,
   input  wire               ENTRY_VALID,
   input  wire               ENTRY_RSVD_NZ,
   input  wire [15:0]        ENTRY_REQUESTER_TAG,
   input  wire [1:0]         ENTRY_REQUESTER_CHECK_KIND,
   input  wire [1:0]         ENTRY_REQUESTER_MATCH_MASK,
   // Fault reports
   output reg                XLAT_FAULT,
   output reg  [7:0]         XLAT_REASON,
   output reg                IRQ_FAULT,
   output reg  [7:0]         IRQ_REASON,
   output reg                IRQ_BLOCK,
   // Interrupt
   output wire               INTR
);

   // ----------------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------------
   reg                wide_irq_id_mode_r;
   reg                legacy_irq_format_on_r;
   reg  [3:0]         table_size_r;
   reg  [1:0]         status_r;
   reg  [1:0]         status_nxt;
   reg  [1:0]         mask_r;
   reg  [7:0]         last_reason_r;
   reg  [COUNT_W-1:0] count_r;
   reg  [COUNT_W-1:0] count_nxt;
   reg  [31:0]        rdata;
   reg                addr_hit;
   wire               wr_en;
   wire               rd_en;
   wire               xlat_hit;
   wire               irq_hit;

   // Per-register write strobes
   wire               ctrl_wr;
   wire               status_wr;
   wire               mask_wr;
   wire               count_wr;

   // Control reset image and counter ceiling
   localparam [31:0]         CTRL_RST  = `RFRE_CTRL_RESET;
   localparam [COUNT_W-1:0]  COUNT_MAX = {COUNT_W{1'b1}};

   // Combinational classifier results
   reg  [7:0]         xlat_code;
   reg  [7:0]         irq_code;
   wire               req_fail;

   // ----------------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------------
   // Slot is out of range if any bit above the table's index width is set;
   // a size field of s gives 2^(s+1) entries.
   function slot_over;
      input [SLOT_W-1:0] slot;
      input [3:0]        size;
      integer            i;
      begin
         slot_over = 1'b0;
         for (i = 1; i < SLOT_W; i = i + 1) begin
            if (slot[i] && (i > size))
               slot_over = 1'b1;
         end
      end
   endfunction

   // Only the defined codes may leave the block
   // Reserved gaps 0Eh-1Fh and 27h-FFh fail both tests
   function code_legal;
      input [7:0] code;
      begin
         code_legal = (code == `RFRE_RSN_PTE_RSVD) || (code == `RFRE_RSN_KIND_BLOCK) ||
                      ((code >= `RFRE_RSN_FMT_RSVD) && (code <= `RFRE_RSN_REQ_CHECK));
      end
   endfunction

   // One register's write strobe; the decode is shared by several processes
   function wr_sel;
      input        wr;
      input [11:0] addr;
      input [11:0] target;
      begin
         wr_sel = wr && (addr == target);
      end
   endfunction

   // ----------------------------------------------------------------------------
   // Requester identity check
   // ----------------------------------------------------------------------------
   rfre_req_check u_req_check (
      .source_id            (IRQ_SOURCE_ID),
      .requester_tag        (ENTRY_REQUESTER_TAG),
      .requester_check_kind (ENTRY_REQUESTER_CHECK_KIND),
      .requester_match_mask (ENTRY_REQUESTER_MATCH_MASK),
      .check_fail           (req_fail)
   );

   // ----------------------------------------------------------------------------
   // Translation classifier
   // ----------------------------------------------------------------------------
   // Context entry is consulted before the page walk, so its block wins
   // Earlier translation codes are raised upstream, not here
   always @* begin
      xlat_code = `RFRE_RSN_NONE;
      if (XLAT_KIND_BLOCKED)
         xlat_code = `RFRE_RSN_KIND_BLOCK;
      else if (XLAT_PTE_RW_SET && XLAT_PTE_RSVD_NZ)
         xlat_code = `RFRE_RSN_PTE_RSVD;
   end

   // ----------------------------------------------------------------------------
   // Interrupt classifier
   // ----------------------------------------------------------------------------
   // Order follows the lookup: decode, index, fetch, entry, identity
   // Fetch error outranks the valid flag: a failed fetch leaves no entry
   // Legacy-format requests skip the remap checks entirely
   always @* begin
      irq_code = `RFRE_RSN_NONE;
      if (!IRQ_REMAPPABLE) begin
         if ((ALT_PLATFORM != 0) || wide_irq_id_mode_r || !legacy_irq_format_on_r)
            irq_code = `RFRE_RSN_LEGACY_BLK;
      end else if (IRQ_FMT_RSVD)
         irq_code = `RFRE_RSN_FMT_RSVD;
      else if (slot_over(IRQ_SLOT, table_size_r))
         irq_code = `RFRE_RSN_SLOT_RANGE;
      else if (IRQ_FETCH_ERR)
         irq_code = `RFRE_RSN_FETCH_ERR;
      else if (!ENTRY_VALID)
         irq_code = `RFRE_RSN_ENTRY_INVAL;
      else if (ENTRY_RSVD_NZ)
         irq_code = `RFRE_RSN_ENTRY_RSVD;
      else if (req_fail)
         irq_code = `RFRE_RSN_REQ_CHECK;
   end

   // ----------------------------------------------------------------------------
   // Fault report registers
   // ----------------------------------------------------------------------------
   // A report fires only with a legal nonzero code; the reason holds between
   assign xlat_hit = XLAT_CHK && code_legal(xlat_code);
   assign irq_hit  = IRQ_CHK && code_legal(irq_code);

   // IRQ_BLOCK mirrors IRQ_FAULT: each interrupt fault here drops the request

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         XLAT_FAULT  <= 1'b0;
         XLAT_REASON <= 8'h00;
         IRQ_FAULT   <= 1'b0;
         IRQ_REASON  <= 8'h00;
         IRQ_BLOCK   <= 1'b0;
      end else begin
         XLAT_FAULT <= xlat_hit;
         IRQ_FAULT  <= irq_hit;
         IRQ_BLOCK  <= irq_hit;
         if (xlat_hit)
            XLAT_REASON <= xlat_code;
         if (irq_hit)
            IRQ_REASON <= irq_code;
      end
   end

   // ----------------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------------
   // Zero wait states: every access completes in its first access cycle
   // Limitation: no byte strobes, each register is one whole word
   assign wr_en   = PSEL && PENABLE && PWRITE;
   assign rd_en   = PSEL && PENABLE && !PWRITE;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !addr_hit;
   assign PRDATA  = rd_en ? rdata : 32'h0000_0000;

   // Per-register write strobes
   assign ctrl_wr   = wr_sel(wr_en, PADDR, `RFRE_ADDR_CTRL);
   assign status_wr = wr_sel(wr_en, PADDR, `RFRE_ADDR_STATUS);
   assign mask_wr   = wr_sel(wr_en, PADDR, `RFRE_ADDR_MASK);
   assign count_wr  = wr_sel(wr_en, PADDR, `RFRE_ADDR_COUNT);

   // Read mux and decode
   always @* begin
      rdata    = 32'h0000_0000;
      addr_hit = 1'b1;
      case (PADDR)
         `RFRE_ADDR_CTRL: begin
            rdata[`RFRE_CTRL_WIDE_BIT]                       = wide_irq_id_mode_r;
            rdata[`RFRE_CTRL_LEGACY_BIT]                     = legacy_irq_format_on_r;
            rdata[`RFRE_CTRL_SIZE_MSB:`RFRE_CTRL_SIZE_LSB]   = table_size_r;
         end
         `RFRE_ADDR_STATUS: rdata[1:0] = status_r;
         `RFRE_ADDR_MASK:   rdata[1:0] = mask_r;
         `RFRE_ADDR_LAST:   rdata[7:0] = last_reason_r;
         `RFRE_ADDR_COUNT:  rdata[COUNT_W-1:0] = count_r;
         default:           addr_hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------------
   // Status and counter next values
   // ----------------------------------------------------------------------------
   // Write-one-to-clear, but a fault in the same cycle keeps its bit set
   always @* begin
      status_nxt = status_r;
      if (status_wr)
         status_nxt = status_r & ~PWDATA[1:0];
      if (xlat_hit)
         status_nxt[`RFRE_ST_XLAT_BIT] = 1'b1;
      if (irq_hit)
         status_nxt[`RFRE_ST_IRQ_BIT] = 1'b1;
      // Counter saturates rather than wrap, so a flood never reads as few
      count_nxt = count_r;
      if ((xlat_hit || irq_hit) && (count_r != COUNT_MAX))
         count_nxt = count_r + {{(COUNT_W-1){1'b0}}, 1'b1};
   end

   // ----------------------------------------------------------------------------
   // Register updates
   // ----------------------------------------------------------------------------
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wide_irq_id_mode_r     <= CTRL_RST[`RFRE_CTRL_WIDE_BIT];
         legacy_irq_format_on_r <= CTRL_RST[`RFRE_CTRL_LEGACY_BIT];
         table_size_r           <= CTRL_RST[`RFRE_CTRL_SIZE_MSB:`RFRE_CTRL_SIZE_LSB];
         status_r               <= 2'h0;
         mask_r                 <= `RFRE_MASK_RESET;
         last_reason_r          <= 8'h00;
         count_r                <= {COUNT_W{1'b0}};
      end else begin
         status_r <= status_nxt;
         count_r  <= count_nxt;
         if (ctrl_wr) begin
            wide_irq_id_mode_r     <= PWDATA[`RFRE_CTRL_WIDE_BIT];
            legacy_irq_format_on_r <= PWDATA[`RFRE_CTRL_LEGACY_BIT];
            table_size_r           <= PWDATA[`RFRE_CTRL_SIZE_MSB:`RFRE_CTRL_SIZE_LSB];
         end
         if (mask_wr)
            mask_r <= PWDATA[1:0];
         // Interrupt fault takes the slot when both fire together
         if (irq_hit)
            last_reason_r <= irq_code;
         else if (xlat_hit)
            last_reason_r <= xlat_code;
         // A count clear drops a fault landing in the same cycle
         if (count_wr)
            count_r <= {COUNT_W{1'b0}};
      end
   end

   // ----------------------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------------------
   // A set mask bit lets its status bit drive the line
   assign INTR = |(status_r & mask_r);

endmodule // rfre_top

// ==== dv/rfre_top_sva.sv ====
// Port-level checks for the fault reason encoder.
// Assumes it is bound into rfre_top and sees only that module's ports.
`timescale 1ns/1ps
module rfre_top_sva #(
   parameter SLOT_W = 16
) (
   // Clock and reset
   input wire              CLK,
   input wire              RESET_N,
   // Check requests
   input wire              XLAT_CHK,
   input wire              XLAT_PTE_RW_SET,
   input wire              XLAT_PTE_RSVD_NZ,
   input wire              XLAT_KIND_BLOCKED,
   input wire              IRQ_CHK,
   input wire              IRQ_REMAPPABLE,
   input wire              IRQ_FMT_RSVD,
   input wire [SLOT_W-1:0] IRQ_SLOT,
   input wire              IRQ_FETCH_ERR,
   input wire              ENTRY_VALID,
   input wire              ENTRY_RSVD_NZ,
   input wire [1:0]        ENTRY_REQUESTER_CHECK_KIND,
   // Reports
   input wire              XLAT_FAULT,
   input wire [7:0]        XLAT_REASON,
   input wire              IRQ_FAULT,
   input wire [7:0]        IRQ_REASON,
   input wire              IRQ_BLOCK
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // Slot zero is in range for every table size, so later ranks show
   chk_xlat_kind_code:
      assert property (XLAT_CHK && XLAT_KIND_BLOCKED |=> XLAT_FAULT && XLAT_REASON == 8'h0d) else $error("bad kind code");
   chk_xlat_pte_code:
      assert property (XLAT_CHK && !XLAT_KIND_BLOCKED && XLAT_PTE_RW_SET && XLAT_PTE_RSVD_NZ |=>
         XLAT_FAULT && XLAT_REASON == 8'h0c) else $error("bad entry code");
   chk_xlat_code_range:
      assert property (XLAT_FAULT |-> XLAT_REASON inside {8'h0c, 8'h0d}) else $error("bad xlat range");
   chk_xlat_reason_hold:
      assert property (!XLAT_FAULT |-> $stable(XLAT_REASON)) else $error("xlat reason moved");
   chk_irq_fmt_code:
      assert property (IRQ_CHK && IRQ_REMAPPABLE && IRQ_FMT_RSVD |=> IRQ_FAULT ##0 IRQ_REASON == 8'h20)
         else $error("bad format code");
   chk_irq_fetch_code:
      assert property (IRQ_CHK && IRQ_REMAPPABLE && !IRQ_FMT_RSVD && IRQ_SLOT == 0 && IRQ_FETCH_ERR |=>
         IRQ_FAULT && IRQ_REASON == 8'h23) else $error("bad fetch code");
   chk_irq_inval_code:
      assert property (IRQ_CHK && IRQ_REMAPPABLE && !IRQ_FMT_RSVD && IRQ_SLOT == 0 && !IRQ_FETCH_ERR &&
         !ENTRY_VALID |=> IRQ_FAULT && IRQ_REASON == 8'h22) else $error("bad invalid code");
   chk_irq_rsvd_code:
      assert property (IRQ_CHK && IRQ_REMAPPABLE && !IRQ_FMT_RSVD && IRQ_SLOT == 0 && !IRQ_FETCH_ERR &&
         ENTRY_VALID && ENTRY_RSVD_NZ |=> IRQ_FAULT && IRQ_REASON == 8'h24) else $error("bad entry reserved code");
   chk_irq_ident_code:
      assert property (IRQ_CHK && IRQ_REMAPPABLE && !IRQ_FMT_RSVD && IRQ_SLOT == 0 && !IRQ_FETCH_ERR &&
         ENTRY_VALID && !ENTRY_RSVD_NZ && ENTRY_REQUESTER_CHECK_KIND == 2'h3 |=> IRQ_REASON == 8'h26)
         else $error("bad identity code");
   chk_irq_code_range:
      assert property (IRQ_FAULT |-> IRQ_BLOCK && IRQ_REASON inside {[8'h20:8'h26]}) else $error("bad irq range");
   chk_irq_pulse_cause:
      assert property (IRQ_FAULT |-> $past(IRQ_CHK)) else $error("irq fault without check");
endmodule // rfre_top_sva
bind rfre_top rfre_top_sva #(.SLOT_W(SLOT_W)) rfre_top_sva_i (.CLK(CLK), .RESET_N(RESET_N),
   .XLAT_CHK(XLAT_CHK), .XLAT_PTE_RW_SET(XLAT_PTE_RW_SET), .XLAT_PTE_RSVD_NZ(XLAT_PTE_RSVD_NZ),
   .XLAT_KIND_BLOCKED(XLAT_KIND_BLOCKED), .IRQ_CHK(IRQ_CHK), .IRQ_REMAPPABLE(IRQ_REMAPPABLE),
   .IRQ_FMT_RSVD(IRQ_FMT_RSVD), .IRQ_SLOT(IRQ_SLOT), .IRQ_FETCH_ERR(IRQ_FETCH_ERR), .ENTRY_VALID(ENTRY_VALID),
   .ENTRY_RSVD_NZ(ENTRY_RSVD_NZ), .ENTRY_REQUESTER_CHECK_KIND(ENTRY_REQUESTER_CHECK_KIND),
   .XLAT_FAULT(XLAT_FAULT), .XLAT_REASON(XLAT_REASON), .IRQ_FAULT(IRQ_FAULT), .IRQ_REASON(IRQ_REASON),
   .IRQ_BLOCK(IRQ_BLOCK));

// ==== dv/rfre_top_tb.sv ====
// Self-checking bench for the fault reason encoder with a reference model.
// Assumes rfre_top with default parameters; checker is bound on its own.
`timescale 1ns/1ps
module rfre_top_tb;
   reg        CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, XLAT_CHK = 0, XLAT_PTE_RW_SET = 0;
   reg        XLAT_PTE_RSVD_NZ = 0, XLAT_KIND_BLOCKED = 0, IRQ_CHK = 0, IRQ_REMAPPABLE = 0, IRQ_FMT_RSVD = 0;
   reg        IRQ_FETCH_ERR = 0, ENTRY_VALID = 0, ENTRY_RSVD_NZ = 0;
   reg [11:0] PADDR = 0;
   reg [31:0] PWDATA = 0;
   reg [15:0] IRQ_SLOT = 0, IRQ_SOURCE_ID = 0, ENTRY_REQUESTER_TAG = 0;
   reg [1:0]  ENTRY_REQUESTER_CHECK_KIND = 0, ENTRY_REQUESTER_MATCH_MASK = 0;
   wire [31:0] PRDATA;
   wire       PREADY, PSLVERR, XLAT_FAULT, IRQ_FAULT, IRQ_BLOCK, INTR;
   wire [7:0] XLAT_REASON, IRQ_REASON;
   integer    miscompares = 0, cmp_count = 0, seed = 74, k, wide, leg, size;
   integer    m_xr = 0, m_ir = 0, m_st = 0, m_last = 0, m_cnt = 0;
   reg [31:0] rd, ctrl;
   reg        er;

   rfre_top rfre_top_i (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .XLAT_CHK(XLAT_CHK), .XLAT_PTE_RW_SET(XLAT_PTE_RW_SET), .XLAT_PTE_RSVD_NZ(XLAT_PTE_RSVD_NZ),
      .XLAT_KIND_BLOCKED(XLAT_KIND_BLOCKED), .IRQ_CHK(IRQ_CHK), .IRQ_REMAPPABLE(IRQ_REMAPPABLE),
      .IRQ_FMT_RSVD(IRQ_FMT_RSVD), .IRQ_SLOT(IRQ_SLOT), .IRQ_SOURCE_ID(IRQ_SOURCE_ID),
      .IRQ_FETCH_ERR(IRQ_FETCH_ERR), .ENTRY_VALID(ENTRY_VALID), .ENTRY_RSVD_NZ(ENTRY_RSVD_NZ),
      .ENTRY_REQUESTER_TAG(ENTRY_REQUESTER_TAG), .ENTRY_REQUESTER_CHECK_KIND(ENTRY_REQUESTER_CHECK_KIND),
      .ENTRY_REQUESTER_MATCH_MASK(ENTRY_REQUESTER_MATCH_MASK), .XLAT_FAULT(XLAT_FAULT),
      .XLAT_REASON(XLAT_REASON), .IRQ_FAULT(IRQ_FAULT), .IRQ_REASON(IRQ_REASON), .IRQ_BLOCK(IRQ_BLOCK),
      .INTR(INTR));

   always #2 CLK = ~CLK;

   // Compare and count
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   // One APB transfer; waits on pready, bounded so a hang cannot stall
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      n = 0;
      @(posedge CLK);
      PSEL <= 1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1;
      @(posedge CLK);
      while (PREADY !== 1'b1 && n < 20) begin
         n++;
         @(posedge CLK);
      end
      rd = PRDATA;
      er = PSLVERR;
      chk("pready", 1, PREADY);
      PSEL <= 0;
      PENABLE <= 0;
   endtask

   // Random check traffic, one strobe per channel per cycle, model-compared
   task run(input integer cnt);
      logic [31:0] r, q;
      logic [15:0] sl, tg, ign;
      integer      xe, ie, px, pi, j, idf;
      px = 0;
      pi = 0;
      for (j = 0; j <= cnt; j++) begin
         @(posedge CLK);
         r = $random(seed);
         q = $random(seed);
         if (j == cnt) r[0] = 0;
         if (j == cnt) r[5] = 0;
         sl = r[31:16] & ((1 << (size + 2)) - 1);
         tg = q[16] ? {q[15:3], q[31:29]} : q[31:16];
         ign = q[20:19] == 0 ? 16'h0 : q[20:19] == 1 ? 16'h4 : q[20:19] == 2 ? 16'h6 : 16'h7;
         case (q[18:17])
            2'h0: idf = 0;
            2'h1: idf = ((q[15:0] ^ tg) & ~ign) != 0;
            2'h2: idf = !(tg[15:8] <= q[15:8] && q[15:8] <= tg[7:0]);
            default: idf = 1;
         endcase
         xe = !r[0] ? 0 : (r[3] & r[4]) ? 8'h0d : (r[1] & r[2]) ? 8'h0c : 0;
         if (!r[5]) ie = 0;
         else if (!(r[6] | r[7])) ie = (wide || !leg) ? 8'h25 : 0;
         else if (r[8] & r[9] & r[10]) ie = 8'h20;
         else if (sl > (1 << (size + 1)) - 1) ie = 8'h21;
         else if (r[11] & r[12] & r[13]) ie = 8'h23;
         else if (!(r[14] | r[15])) ie = 8'h22;
         else if (q[21] & q[22]) ie = 8'h24;
         else ie = idf ? 8'h26 : 0;
         XLAT_CHK <= r[0];
         XLAT_PTE_RW_SET <= r[1];
         XLAT_PTE_RSVD_NZ <= r[2];
         XLAT_KIND_BLOCKED <= r[3] & r[4];
         IRQ_CHK <= r[5];
         IRQ_REMAPPABLE <= r[6] | r[7];
         IRQ_FMT_RSVD <= r[8] & r[9] & r[10];
         IRQ_SLOT <= sl;
         IRQ_FETCH_ERR <= r[11] & r[12] & r[13];
         ENTRY_VALID <= r[14] | r[15];
         ENTRY_RSVD_NZ <= q[21] & q[22];
         IRQ_SOURCE_ID <= q[15:0];
         ENTRY_REQUESTER_TAG <= tg;
         ENTRY_REQUESTER_CHECK_KIND <= q[18:17];
         ENTRY_REQUESTER_MATCH_MASK <= q[20:19];
         #1;
         if (px > 0) m_xr = px;
         if (pi > 0) m_ir = pi;
         m_st = m_st | (px > 0) | ((pi > 0) << 1);
         m_last = pi > 0 ? pi : px > 0 ? px : m_last;
         m_cnt = m_cnt + ((px > 0) || (pi > 0));
         chk("xlat fault", px > 0, XLAT_FAULT);
         chk("xlat reason", m_xr, XLAT_REASON);
         chk("irq fault", pi > 0, IRQ_FAULT);
         chk("irq block", pi > 0, IRQ_BLOCK);
         chk("irq reason", m_ir, IRQ_REASON);
         px = xe;
         pi = ie;
      end
   endtask

   task finish_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Watchdog, far beyond the expected run of about a thousand cycles
   initial begin
      #100000;
      miscompares++;
      finish_test;
   end

   // Main sequence: reset values, then eight control settings with traffic
   initial begin
      repeat (2) @(posedge CLK);
      RESET_N <= 1;
      for (k = 0; k < 5; k++) begin
         apb(0, 4 * k, 0);
         chk("reset value", k == 0 ? 2 : 0, rd);
         chk("mapped error", 0, er);
      end
      apb(0, 12'h014, 0);
      chk("unmapped error", 1, er);
      chk("unmapped data", 0, rd);
      for (k = 0; k < 8; k++) begin
         wide = k & 1;
         leg = (k >> 1) & 1;
         size = (3 * k) % 16;
         ctrl = (size << 4) | (leg << 1) | wide;
         apb(1, 12'h000, ctrl);
         apb(0, 12'h000, 0);
         chk("ctrl", ctrl, rd);
         run(80);
         apb(0, 12'h004, 0);
         chk("status", m_st, rd);
         apb(0, 12'h00c, 0);
         chk("last", m_last, rd);
         apb(1, 12'h008, k % 4);
         repeat (2) @(posedge CLK);
         chk("intr masked", (m_st & (k % 4)) != 0, INTR);
         apb(1, 12'h004, 3);
         m_st = 0;
         repeat (2) @(posedge CLK);
         chk("intr cleared", 0, INTR);
      end
      apb(0, 12'h010, 0);
      chk("count model", m_cnt, rd);
      apb(1, 12'h010, 0);
      apb(0, 12'h010, 0);
      chk("count", 0, rd);
      finish_test;
   end
endmodule // rfre_top_tb
